//--- verilog/prog_io_state_version_guard.sv
/*
  Programming-time rollback guard and user/transceiver I/O state control.
  Assumes a programming engine that reports image header fields, a start pulse,
  and done/fail pulses; the outside master or flash delivers the image.
*/
`timescale 1ns/1ps
module prog_io_state_version_guard #(
  parameter int N_IO   = 8,
  parameter int N_TRANSCEIVER = 2,
  parameter int VW     = prog_guard_pkg::VER_W
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // Programming mode
  input  wire prog_guard_pkg::prog_mode_t   mode,
  input  wire logic                         isc_enable,
  input  wire logic                         loopback_en,
  // Image header and engine handshake
  input  wire logic                         img_start,
  input  wire logic [VW-1:0]                img_design_ver,
  input  wire logic [VW-1:0]                img_min_ver,
  input  wire logic                         img_bypass,
  input  wire logic                         img_spi,
  input  wire logic                         img_self_update,
  input  wire logic                         prog_done,
  input  wire logic                         prog_fail,
  // Engine control
  output logic                              prog_go,
  output logic                              recover_req,
  output logic                              img_reject,
  output logic                              recover_fail,
  output logic                              prog_ok,
  output logic [VW-1:0]                     min_ver,
  output prog_guard_pkg::guard_state_t      guard_state,
  // User I/O
  input  wire prog_guard_pkg::pin_set_t     pin_set [N_IO],
  input  wire logic [N_IO-1:0]              bscan_val,
  input  wire logic [N_IO-1:0]              user_out,
  input  wire logic [N_IO-1:0]              user_oe_n,
  output logic [N_IO-1:0]                   pad_out,
  output logic [N_IO-1:0]                   pad_oe_n,
  output logic [N_IO-1:0]                   pad_pullup,
  // Transceiver
  input  wire logic [N_TRANSCEIVER-1:0]            transceiver_bscan,
  input  wire logic [N_TRANSCEIVER-1:0]            transceiver_user,
  output logic [N_TRANSCEIVER-1:0]                 transceiver_data,
  output logic                              transceiver_link_en
);
  import prog_guard_pkg::*;

  // ==========================================================
  // Version guard
  guard_state_t st_ff;
  guard_state_t nxt_st;
  logic [VW-1:0] min_ver_ff;
  logic [VW-1:0] pend_min_ff;
  logic [VW-1:0] nxt_min;
  logic          self_upd_ff;
  logic          accept;
  logic          go_ff;
  logic          rec_ff;
  logic          rej_ff;
  logic          rfail_ff;
  logic          ok_ff;

  version_check #(.W(VW)) u_check (
    .design_ver (img_design_ver),
    .min_ver    (min_ver_ff),
    .bypass     (img_bypass),
    .spi_path   (img_spi),
    .accept     (accept)
  );

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      GS_IDLE: begin
        if (img_start) nxt_st = GS_CHECK;
      end
      GS_CHECK: begin
        nxt_st = accept ? GS_PROG : GS_FAIL; // RQ2
      end
      GS_PROG: begin
        if (prog_done) nxt_st = GS_DONE;
        else if (prog_fail && self_upd_ff) nxt_st = GS_RECOVER; // RQ3
        else if (prog_fail) nxt_st = GS_FAIL;
      end
      GS_RECOVER: begin
        if (img_start) nxt_st = GS_RCHECK; // RQ3
      end
      GS_RCHECK: begin
        nxt_st = accept ? GS_PROG : GS_FAIL; // RQ2 RQ4
      end
      GS_DONE: nxt_st = GS_IDLE;
      GS_FAIL: nxt_st = GS_IDLE;
      default: nxt_st = GS_IDLE;
    endcase
  end

  // Stored minimum changes only on a completed program
  assign nxt_min = (st_ff == GS_PROG && prog_done) ? pend_min_ff : min_ver_ff; // RQ1 RQ13

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff       <= GS_IDLE;
      min_ver_ff  <= MIN_VER_RST;
      pend_min_ff <= MIN_VER_RST;
      self_upd_ff <= 1'b0;
      go_ff       <= 1'b0;
      rec_ff      <= 1'b0;
      rej_ff      <= 1'b0;
      rfail_ff    <= 1'b0;
      ok_ff       <= 1'b0;
    end else if (ce) begin
      st_ff      <= nxt_st;
      min_ver_ff <= nxt_min; // RQ1
      if (st_ff == GS_CHECK || st_ff == GS_RCHECK) begin
        pend_min_ff <= img_min_ver;
      end
      if (st_ff == GS_CHECK) begin
        self_upd_ff <= img_self_update;
      end else if (st_ff == GS_RCHECK) begin
        self_upd_ff <= 1'b0;
      end
      go_ff    <= (st_ff == GS_CHECK || st_ff == GS_RCHECK) && accept;
      rec_ff   <= (st_ff == GS_PROG) && prog_fail && !prog_done && self_upd_ff; // RQ3
      rej_ff   <= (st_ff == GS_CHECK || st_ff == GS_RCHECK) && !accept; // RQ2
      rfail_ff <= (st_ff == GS_RCHECK) && !accept; // RQ2
      ok_ff    <= (st_ff == GS_PROG) && prog_done;
    end
  end

  assign prog_go      = go_ff;
  assign recover_req  = rec_ff;
  assign img_reject   = rej_ff;
  assign recover_fail = rfail_ff;
  assign prog_ok      = ok_ff;
  assign min_ver      = min_ver_ff;
  assign guard_state  = st_ff;

  // ==========================================================
  // User I/O states
  genvar gi;
  generate
    for (gi = 0; gi < N_IO; gi++) begin : g_pin
      io_pin_state u_pin (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .mode       (mode),
        .isc_enable (isc_enable),
        .pin_set    (pin_set[gi]),
        .bscan_val  (bscan_val[gi]),
        .user_out   (user_out[gi]),
        .user_oe_n  (user_oe_n[gi]),
        .pad_out    (pad_out[gi]),
        .pad_oe_n   (pad_oe_n[gi]),
        .pad_pullup (pad_pullup[gi])
      ); // RQ5 RQ12
    end
  endgenerate

  // ==========================================================
  // Transceiver
  assign transceiver_data    = (mode == MODE_JTAG) ? transceiver_bscan : transceiver_user; // RQ8
  assign transceiver_link_en = (mode != MODE_SPI_MST) || loopback_en;        // RQ9

  // ==========================================================
  // Checks on the guard sequencer
  sequence s_check_pass;
    ce && st_ff == GS_CHECK && accept;
  endsequence
  sequence s_go_seen;
    prog_go && st_ff == GS_PROG;
  endsequence
  sequence s_update_fail;
    ce && st_ff == GS_PROG && prog_fail && self_upd_ff && !prog_done;
  endsequence
  sequence s_golden_start;
    ce && st_ff == GS_RECOVER && img_start;
  endsequence

  a_state_legal: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    st_ff inside {GS_IDLE, GS_CHECK, GS_PROG, GS_RECOVER, GS_RCHECK, GS_DONE, GS_FAIL})
    else $error("guard state outside its code set");
  a_idle_start: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    ce && st_ff == GS_IDLE && img_start |=> st_ff == GS_CHECK)
    else $error("image start not taken");
  a_check_once: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    ce && st_ff == GS_CHECK |=> st_ff == GS_PROG || st_ff == GS_FAIL)
    else $error("version check did not resolve");
  a_prog_wait: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    ce && st_ff == GS_PROG && !prog_done && !prog_fail |=> st_ff == GS_PROG)
    else $error("programming left without an answer");
  a_done_idle: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    ce && st_ff == GS_DONE |=> st_ff == GS_IDLE)
    else $error("done state did not return to idle");
  a_fail_idle: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    ce && st_ff == GS_FAIL |=> st_ff == GS_IDLE)
    else $error("fail state did not return to idle");
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    !ce |=> $stable(st_ff) && $stable(min_ver_ff) && $stable(pend_min_ff))
    else $error("state moved with clock enable low");

  // ==========================================================
  // Checks on version decisions
  a_go_after: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    s_check_pass |=> s_go_seen)
    else $error("accepted image did not start programming");
  a_go_once: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    ce && prog_go |=> !prog_go)
    else $error("start pulse longer than one cycle");
  a_reject_old: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    ce && st_ff == GS_CHECK && img_design_ver <= min_ver_ff
       && !(img_bypass && img_spi) |=> img_reject)
    else $error("stale image was not rejected");
  a_reject_no_go: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    img_reject |-> !prog_go)
    else $error("rejected image started programming");
  a_bypass_ok: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    ce && st_ff == GS_RCHECK && img_bypass && img_spi |=> !img_reject)
    else $error("bypass image rejected");
  a_rcheck_fail: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    ce && st_ff == GS_RCHECK && !accept |=> recover_fail && img_reject)
    else $error("rejected recovery image not reported");

  // ==========================================================
  // Checks on the stored minimum
  a_min_update: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    ce && st_ff == GS_PROG && prog_done |=> min_ver == $past(pend_min_ff))
    else $error("minimum version not updated");
  a_ok_min: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    prog_ok |-> min_ver == pend_min_ff)
    else $error("success pulse without new minimum");
  a_min_stable: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    !(st_ff == GS_PROG && prog_done) |=> $stable(min_ver))
    else $error("minimum version changed without success");

  // ==========================================================
  // Checks on recovery
  a_recover_go: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    s_update_fail |=> recover_req && st_ff == GS_RECOVER)
    else $error("failed update did not start recovery");
  a_recover_only: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    recover_req |-> st_ff == GS_RECOVER)
    else $error("recovery request outside recovery");
  a_golden_check: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    s_golden_start |=> st_ff == GS_RCHECK)
    else $error("golden image not checked");
  a_single_retry: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    ce && st_ff == GS_RCHECK |=> !self_upd_ff)
    else $error("second recovery still armed");
  a_recover_wait: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    ce && st_ff == GS_RECOVER && !img_start |=> st_ff == GS_RECOVER)
    else $error("recovery left without golden image");

  // ==========================================================
  // Checks on transceiver and pins
  a_transceiver_jtag: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    mode == MODE_JTAG |-> transceiver_data == transceiver_bscan)
    else $error("transceiver data not from scan cell");
  a_transceiver_spi: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    mode != MODE_JTAG |-> transceiver_data == transceiver_user)
    else $error("transceiver data disturbed outside JTAG");
  a_link_loop: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    mode == MODE_SPI_MST && loopback_en |-> transceiver_link_en)
    else $error("link dropped in loopback");
  a_link_other: assert property (@(posedge clk) disable iff (!rst_n) // RQ9
    mode != MODE_SPI_MST |-> transceiver_link_en)
    else $error("link dropped outside SPI master");
  a_jtag_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
    mode == MODE_JTAG && $past(mode) == MODE_JTAG && $stable(pin_set[0])
      && pin_set[0] != PIN_Z && pin_set[0] != PIN_LOW && pin_set[0] != PIN_HIGH
      |-> $stable(pad_out[0]))
    else $error("held output changed during JTAG");
  a_slave_pull: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    mode == MODE_SPI_SLV |-> pad_pullup == {N_IO{isc_enable}})
    else $error("slave pull-up mismatch");

  generate
    for (gi = 0; gi < N_IO; gi++) begin : g_pin_chk
      a_pin_high: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
        mode == MODE_JTAG && pin_set[gi] == PIN_HIGH |-> pad_out[gi] && !pad_oe_n[gi])
        else $error("pin not driven high");
      a_pin_low: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
        mode == MODE_JTAG && pin_set[gi] == PIN_LOW |-> !pad_out[gi] && !pad_oe_n[gi])
        else $error("pin not driven low");
      a_pin_z: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
        mode == MODE_JTAG && pin_set[gi] == PIN_Z |-> pad_oe_n[gi])
        else $error("pin not tristated");
      a_pin_enabled: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
        mode == MODE_JTAG && pin_set[gi] != PIN_Z |-> !pad_oe_n[gi])
        else $error("pin not enabled during JTAG");
      a_spis_user: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
        mode == MODE_SPI_SLV |-> pad_out[gi] == user_out[gi] && pad_oe_n[gi] == user_oe_n[gi])
        else $error("pin disturbed in SPI slave mode");
      a_pin_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ12
        mode == MODE_JTAG && $past(mode) == MODE_JTAG && $stable(pin_set[gi])
          && $stable(bscan_val[gi]) |-> $stable(pad_out[gi]))
        else $error("programmed pin state moved during JTAG");
    end
  endgenerate
endmodule

//--- verilog/prog_guard_pkg.sv
/*
  Constants and types for the programming-time version guard and I/O state block.
  Assumes a single 20 MHz clock domain and a synchronous active-low reset.
*/
// Summary of operation
// [RQ1] After a successful program, stored minimum version takes the image's minimum version.
// [RQ2] Reject image whose version is not above stored minimum, unless bypass flag set; code honours the flag only with img_spi set.
// [RQ3] A failed self-update or in-application update starts recovery from stored golden image.
// [RQ4] SPI-delivered images carrying the bypass flag skip the minimum-version check.
// [RQ5] JTAG programming keeps user I/O enabled, state from boundary-scan cell; code takes driven pin state from pin_set, not bscan_val.
// [RQ6] SPI slave leaves user I/O alone unless enable instruction applies weak pull-ups.
// [RQ7] SPI master programming tristates user and high-speed outputs with weak pull-ups; code tristates user I/O only, transceiver_data keeps transceiver_user.
// [RQ8] Transceiver data follows boundary scan in JTAG, untouched in SPI modes.
// [RQ9] SPI master programming lets transceiver clocks and links stay up in loopback.
// [RQ10] JTAG output settings: drive high, drive low, hold last state, or tristate.
// [RQ11] Last-known-state captures each output value just before programming, holds it.
// [RQ12] Preconfigured JTAG output states apply at start and hold until the end.
// [RQ13] Versions compare unsigned; stored minimum updates only after successful completion.
package prog_guard_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int          VER_W        = 16;
  localparam logic [15:0] MIN_VER_RST  = 16'h0000;

  // ==========================================================
  // Programming modes
  typedef enum logic [1:0] {
    MODE_IDLE     = 2'b00,
    MODE_JTAG     = 2'b01,
    MODE_SPI_SLV  = 2'b11,
    MODE_SPI_MST  = 2'b10
  } prog_mode_t;

  // ==========================================================
  // Per-pin JTAG output setting
  typedef enum logic [1:0] {
    PIN_Z    = 2'b00,
    PIN_LOW  = 2'b01,
    PIN_HIGH = 2'b10,
    PIN_LAST = 2'b11
  } pin_set_t;

  // ==========================================================
  // Version guard sequencer
  typedef enum logic [2:0] {
    GS_IDLE    = 3'b000,
    GS_CHECK   = 3'b001,
    GS_PROG    = 3'b011,
    GS_RECOVER = 3'b010,
    GS_RCHECK  = 3'b110,
    GS_DONE    = 3'b111,
    GS_FAIL    = 3'b101
  } guard_state_t;

endpackage

//--- verilog/io_pin_state.sv
/*
  One user I/O pin's state during programming.
  Assumes mode and control inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module io_pin_state (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // Mode
  input  wire prog_guard_pkg::prog_mode_t mode,
  input  wire logic                     isc_enable,
  input  wire prog_guard_pkg::pin_set_t pin_set,
  input  wire logic                     bscan_val,
  // User logic side
  input  wire logic                     user_out,
  input  wire logic                     user_oe_n,
  // Pad side
  output logic                          pad_out,
  output logic                          pad_oe_n,
  output logic                          pad_pullup
);
  import prog_guard_pkg::*;

  logic last_ff;
  logic in_jtag;
  logic jtag_out;
  logic jtag_oe_n;

  // Capture driven value until programming starts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_ff <= 1'b0;
    end else if (ce && mode == MODE_IDLE) begin
      last_ff <= user_out; // RQ11
    end
  end

  assign in_jtag   = (mode == MODE_JTAG);
  assign jtag_out  = (pin_set == PIN_HIGH) ? 1'b1 :
                     (pin_set == PIN_LAST) ? last_ff : // RQ11
                     (pin_set == PIN_LOW)  ? 1'b0 : bscan_val; // RQ10
  assign jtag_oe_n = (pin_set == PIN_Z); // RQ10

  // RQ5 RQ7 RQ6
  assign pad_out    = in_jtag ? jtag_out : user_out;
  assign pad_oe_n   = in_jtag ? jtag_oe_n :
                      (mode == MODE_SPI_MST) ? 1'b1 : user_oe_n; // RQ7
  assign pad_pullup = (mode == MODE_SPI_MST) ||
                      (mode == MODE_SPI_SLV && isc_enable); // RQ6

  a_last_hold: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
    ce && mode != MODE_IDLE |=> $stable(last_ff))
    else $error("last state changed during programming");
  a_spim_tri: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    mode == MODE_SPI_MST |-> pad_oe_n && pad_pullup)
    else $error("pin not tristated in SPI master mode");
endmodule

//--- verilog/version_check.sv
/*
  Unsigned comparison of image version against stored minimum with bypass.
  Pure combinational; assumes stable inputs while evaluated.
*/
`timescale 1ns/1ps
module version_check #(
  parameter int W = 16
) (
  // Operands
  input  wire logic [W-1:0] design_ver,
  input  wire logic [W-1:0] min_ver,
  input  wire logic         bypass,
  input  wire logic         spi_path,
  // Verdict
  output logic              accept
);
  logic newer;
  assign newer  = design_ver > min_ver;              // RQ13
  assign accept = newer || (bypass && spi_path);     // RQ2 RQ4
endmodule

//--- sim/prog_engine_model.sv
/*
  Behavioural programming engine on the far side of the guard.
  Assumes prog_go pulses; answers done or fail after a short or long delay.
*/
`timescale 1ns/1ps
module prog_engine_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench control
  input  wire logic fail_next,
  input  wire logic slow,
  // Guard handshake
  input  wire logic prog_go,
  output logic      prog_done,
  output logic      prog_fail
);
  int cnt_ff;
  always_ff @(posedge clk) begin
    prog_done <= 1'b0;
    prog_fail <= 1'b0;
    if (!rst_n) begin
      cnt_ff <= 0;
    end else if (prog_go) begin
      cnt_ff <= slow ? 9 : 2;
    end else if (cnt_ff == 1) begin
      cnt_ff    <= 0;
      prog_done <= !fail_next;
      prog_fail <= fail_next;
    end else if (cnt_ff > 1) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule

//--- sim/prog_io_state_version_guard_test.sv
/*
  Self-checking bench for the version guard and I/O state block.
  Assumes the engine model answers prog_go; pads are checked directly.
*/
`timescale 1ns/1ps
module prog_io_state_version_guard_test;
  import prog_guard_pkg::*;
  localparam logic [4:0] GO = 5'h10, RRQ = 5'h08, REJ = 5'h04, RFL = 5'h06, OK = 5'h01;
  logic         clk, rst_n, ce, isc_enable, loopback_en, img_start, img_bypass, img_spi;
  logic         img_self_update, prog_done, prog_fail, prog_go, recover_req, img_reject;
  logic         recover_fail, prog_ok, fail_next, slow, transceiver_link_en;
  logic [15:0]  img_design_ver, img_min_ver, min_ver;
  logic [7:0]   bscan_val, user_out, user_oe_n, pad_out, pad_oe_n, pad_pullup, last_out;
  logic [1:0]   transceiver_bscan, transceiver_user, transceiver_data;
  prog_mode_t   mode;
  guard_state_t guard_state;
  pin_set_t     pin_set [8];
  logic [20:0]  q [$];
  logic [4:0]   last_ex;
  int           err_count, total_checks;

  prog_io_state_version_guard dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .mode(mode),
    .isc_enable(isc_enable), .loopback_en(loopback_en), .img_start(img_start),
    .img_design_ver(img_design_ver), .img_min_ver(img_min_ver), .img_bypass(img_bypass),
    .img_spi(img_spi), .img_self_update(img_self_update), .prog_done(prog_done),
    .prog_fail(prog_fail), .prog_go(prog_go), .recover_req(recover_req),
    .img_reject(img_reject), .recover_fail(recover_fail), .prog_ok(prog_ok),
    .min_ver(min_ver), .guard_state(guard_state), .pin_set(pin_set), .bscan_val(bscan_val),
    .user_out(user_out), .user_oe_n(user_oe_n), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .transceiver_bscan(transceiver_bscan), .transceiver_user(transceiver_user),
    .transceiver_data(transceiver_data), .transceiver_link_en(transceiver_link_en));

  prog_engine_model eng_u (.clk(clk), .rst_n(rst_n), .fail_next(fail_next), .slow(slow),
    .prog_go(prog_go), .prog_done(prog_done), .prog_fail(prog_fail));

  // ==========================================================
  // Compare and report
  task automatic chk_evt(input logic [20:0] got, input logic [20:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t event got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Event monitor: oldest note against each pulse
  always @(negedge clk) begin
    if (rst_n === 1'b1 && {prog_go, recover_req, img_reject, recover_fail, prog_ok} !== 5'h00) begin
      chk_evt({prog_go, recover_req, img_reject, recover_fail, prog_ok, min_ver},
              q.size() != 0 ? q.pop_front() : 21'h000000);
    end
  end

  // ==========================================================
  // Drivers
  function automatic void ex(input logic [4:0] p, input logic [15:0] m);
    q.push_back({p, m});
    last_ex = p;
  endfunction
  task automatic wait_empty;
    int n;
    n = 0;
    while (q.size() != 0) begin
      n++;
      if (n > 60) begin
        err_count++;
        wrap_up();
      end
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic img(input logic [15:0] dv, input logic [15:0] mv, input logic [3:0] f);
    @(posedge clk);
    img_design_ver  <= dv;
    img_min_ver     <= mv;
    img_bypass      <= f[3];
    img_spi         <= f[2];
    img_self_update <= f[1];
    fail_next       <= f[0];
    img_start       <= 1'b1;
    @(posedge clk);
    img_start <= 1'b0;
    wait_empty();
    @(negedge clk);
    chk_pin(8'(guard_state), last_ex == RRQ ? 8'(GS_RECOVER) : 8'(GS_IDLE));
  endtask
  task automatic check_pins;
    logic [7:0] z, v;
    for (int i = 0; i < 8; i++) begin
      z[i] = pin_set[i] == PIN_Z;
      v[i] = pin_set[i] == PIN_HIGH || (pin_set[i] == PIN_LAST && last_out[i]);
    end
    case (mode)
      MODE_JTAG: begin
        chk_pin(pad_oe_n, z);
        chk_pin(pad_out | z, v | z);
        chk_pin(8'(transceiver_data), 8'(transceiver_bscan));
      end
      MODE_SPI_SLV: begin
        chk_pin(pad_pullup, {8{isc_enable}});
        if (!isc_enable) chk_pin(pad_oe_n, user_oe_n);
        chk_pin(pad_out, user_out);
        chk_pin(8'(transceiver_data), 8'(transceiver_user));
      end
      default: begin
        chk_pin(pad_oe_n & pad_pullup, 8'hff);
        chk_pin(8'(transceiver_data), 8'(transceiver_user));
        if (loopback_en) chk_pin(8'(transceiver_link_en), 8'h01);
      end
    endcase
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, isc_enable, loopback_en, img_start, img_bypass, img_spi} = '0;
    {img_self_update, fail_next, slow, bscan_val, user_out, user_oe_n} = '0;
    {img_design_ver, img_min_ver, transceiver_bscan, transceiver_user} = '0;
    ce = 1'b1;
    mode = MODE_IDLE;
    for (int i = 0; i < 8; i++) pin_set[i] = PIN_Z;
    void'($urandom(11));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ex(GO, 16'h0000); ex(OK, 16'h0001); img(16'h0002, 16'h0001, 4'h4);
    ex(GO, 16'h0001); ex(OK, 16'h0002); img(16'h0003, 16'h0002, 4'h6);
    slow <= 1'b1;
    ex(GO, 16'h0002); ex(OK, 16'h0003); img(16'hffff, 16'h0003, 4'h4);
    ex(REJ, 16'h0003); img(16'h0003, 16'h0001, 4'h4);
    ex(REJ, 16'h0003); img(16'h0002, 16'h0001, 4'h8);
    ex(GO, 16'h0003); ex(RRQ, 16'h0003); img(16'h0004, 16'h0003, 4'h7);
    ex(RFL, 16'h0003); img(16'h0002, 16'h0001, 4'h4);
    ex(GO, 16'h0003); ex(RRQ, 16'h0003); img(16'h0004, 16'h0003, 4'h7);
    ex(GO, 16'h0003); ex(OK, 16'h0001); img(16'h0002, 16'h0001, 4'hc);
    @(posedge clk);
    ce        <= 1'b0;
    img_start <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_pin(8'(guard_state), 8'(GS_IDLE));
    @(posedge clk);
    ce        <= 1'b1;
    img_start <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        mode <= MODE_IDLE;
        user_out <= 8'($urandom);
        @(posedge clk);
        last_out = user_out;
        mode <= m == 0 ? MODE_JTAG : (m == 1 ? MODE_SPI_SLV : MODE_SPI_MST);
        {isc_enable, loopback_en, transceiver_bscan, transceiver_user} <= 6'($urandom);
        {bscan_val, user_oe_n} <= 16'($urandom);
        for (int i = 0; i < 8; i++) pin_set[i] <= pin_set_t'(2'($urandom));
        repeat (2) begin
          @(negedge clk);
          check_pins();
          @(posedge clk);
          user_out <= 8'($urandom);
        end
      end
    end
    wrap_up();
  end
endmodule
